// File: inc/qasc_pkg.sv
// Constants and types of the four-input converter serial control block
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package qasc_pkg;

    // ---------------------------------------------------------------------
    // Frame and word geometry
    // ---------------------------------------------------------------------
    localparam int RESULT_W = 12;
    localparam int SLOT_CLKS = 16;
    localparam int CTRL_W = 8;
    localparam int TRACK_CLKS = 3;
    localparam int MSB_FALL = 4;

    // Control word field positions
    localparam int CHAN_LOW_POS = 3;
    localparam int CHAN_MID_POS = 4;
    localparam int CHAN_TOP_POS = 5;

    // Index widths and counter constants
    localparam int FIDX_W = 5;
    localparam int RIDX_W = 4;
    localparam logic [FIDX_W-1:0] FIDX_NONE = 5'h00;
    localparam logic [FIDX_W-1:0] FIDX_FIRST = 5'h01;
    localparam logic [FIDX_W-1:0] FIDX_TRACK_LAST = 5'h03;
    localparam logic [FIDX_W-1:0] FIDX_MSB = 5'h04;
    localparam logic [FIDX_W-1:0] FIDX_LAST = 5'h10;
    localparam logic [RIDX_W-1:0] RIDX_FIRST = 4'h0;
    localparam logic [RIDX_W-1:0] RIDX_CTRL_END = 4'h8;
    localparam logic [RIDX_W-1:0] RIDX_LAST = 4'hf;

    // Reset values
    localparam logic [1:0] CHAN_DEFAULT = 2'h0;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

    // Synchroniser bit positions and idle levels of the pins
    localparam int PIN_CS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_DIN = 2;
    localparam logic [2:0] PINS_IDLE = 3'h1;

    // Host-side clock ceiling, kept for reference by the bench
    localparam real SCLK_MAX_MHZ = 3.2;

    // ---------------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------------
    // Codes of the four analog inputs as delivered by the converter core
    typedef struct packed {
        logic [RESULT_W-1:0] analog_input_4;
        logic [RESULT_W-1:0] analog_input_3;
        logic [RESULT_W-1:0] analog_input_2;
        logic [RESULT_W-1:0] analog_input_1;
    } qasc_inputs_type;

    // Phase of the current 16-clock slot
    typedef enum logic [1:0] {
        QASC_IDLE,
        QASC_TRACK,
        QASC_CONVERT,
        QASC_SLEEP
    } qasc_phase_type;

endpackage : qasc_pkg

// File: design/qasc_serial_ctrl.sv
// Serial control and readout of a four-input 12-bit converter
module qasc_serial_ctrl
    import qasc_pkg::*;
#(
    parameter int RES_W = RESULT_W,
    parameter int SLOT_LEN = SLOT_CLKS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Serial pins from the host
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    // Serial output pin, three-state: data and its enable
    output logic dout,
    output logic dout_oe,
    // Converter core codes
    input wire qasc_inputs_type conv_codes,
    // Status to the rest of the device
    output logic powered,
    output logic tracking,
    output logic [1:0] active_channel,
    output logic [CTRL_W-1:0] channel_select_control,
    output logic [RES_W-1:0] last_result,
    output logic result_valid
);

    // ---------------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------------
    // The counters and shifter are sized for the documented geometry only
    if (RES_W != RESULT_W || SLOT_LEN != SLOT_CLKS)
    begin : gen_bad_geometry
        $error("qasc_serial_ctrl supports only 12-bit results in 16-clock slots");
    end

    // ---------------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------------
    logic [2:0] pins_raw;
    logic [2:0] pins_meta_ff;
    logic [2:0] pins_sync_ff;
    logic cs_prev_ff;
    logic sclk_prev_ff;

    assign pins_raw = {din, sclk, cs_n};

    // Two flops per pin; the first is read only by the second
    for (genvar i = 0; i < 3; i++)
    begin : gen_sync
        always_ff @(posedge clock)
        begin
            if (srst)
            begin
                pins_meta_ff[i] <= PINS_IDLE[i];
                pins_sync_ff[i] <= PINS_IDLE[i];
            end
            else
            begin
                pins_meta_ff[i] <= pins_raw[i];
                pins_sync_ff[i] <= pins_meta_ff[i];
            end
        end
    end

    // Previous synchronised levels for edge detection
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            cs_prev_ff <= PINS_IDLE[PIN_CS];
            sclk_prev_ff <= PINS_IDLE[PIN_SCLK];
        end
        else
        begin
            cs_prev_ff <= pins_sync_ff[PIN_CS];
            sclk_prev_ff <= pins_sync_ff[PIN_SCLK];
        end
    end

    // ---------------------------------------------------------------------
    // Edge decode
    // ---------------------------------------------------------------------
    wire cs_low = ~pins_sync_ff[PIN_CS];
    wire din_sync = pins_sync_ff[PIN_DIN];
    wire frame_open = cs_prev_ff & cs_low;
    // Clock edges count only inside a frame; chip select gates the clock off
    wire sclk_rise = cs_low & ~cs_prev_ff & ~sclk_prev_ff & pins_sync_ff[PIN_SCLK];
    wire sclk_fall = cs_low & ~cs_prev_ff & sclk_prev_ff & ~pins_sync_ff[PIN_SCLK];
    // Chip select falling onto a low clock acts as the first falling edge
    wire open_low = frame_open & ~pins_sync_ff[PIN_SCLK];
    // Chip select falling together with the clock also lands here: next rise is first
    wire fall_event = sclk_fall | open_low;

    // ---------------------------------------------------------------------
    // Slot counters
    // ---------------------------------------------------------------------
    logic [FIDX_W-1:0] fidx_ff;
    logic [FIDX_W-1:0] nxt_fidx;
    logic [RIDX_W-1:0] ridx_ff;
    logic [RIDX_W-1:0] nxt_ridx;

    // Falling-edge index of the slot: 0 none yet, 1..16 after that edge
    assign nxt_fidx = frame_open ? (open_low ? FIDX_FIRST : FIDX_NONE) :
                      ~cs_low ? FIDX_NONE :
                      ~sclk_fall ? fidx_ff :
                      (fidx_ff == FIDX_LAST) ? FIDX_FIRST :
                      fidx_ff + FIDX_FIRST;

    // Rising-edge index: restarts at each frame and wraps after the 16th
    assign nxt_ridx = (frame_open | ~cs_low) ? RIDX_FIRST :
                      ~sclk_rise ? ridx_ff :
                      (ridx_ff == RIDX_LAST) ? RIDX_FIRST :
                      ridx_ff + 4'h1;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            fidx_ff <= FIDX_NONE;
            ridx_ff <= RIDX_FIRST;
        end
        else
        begin
            fidx_ff <= nxt_fidx;
            ridx_ff <= nxt_ridx;
        end
    end

    // ---------------------------------------------------------------------
    // Slot phase
    // ---------------------------------------------------------------------
    qasc_phase_type phase;

    // Power follows the falling edges: on from the 1st, off after the 16th
    always_comb
    begin
        priority case (1'b1)
            ~cs_low: phase = QASC_IDLE;
            (nxt_fidx == FIDX_NONE): phase = QASC_SLEEP;
            (nxt_fidx == FIDX_LAST): phase = QASC_SLEEP;
            (nxt_fidx <= FIDX_TRACK_LAST): phase = QASC_TRACK;
            default: phase = QASC_CONVERT;
        endcase
    end

    wire nxt_powered = (phase == QASC_TRACK) | (phase == QASC_CONVERT);
    wire nxt_tracking = (phase == QASC_TRACK);

    // ---------------------------------------------------------------------
    // Control word capture
    // ---------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_shift_ff;
    logic [CTRL_W-1:0] ctrl_word_ff;
    logic [1:0] chan_ff;
    logic [1:0] chan_next_ff;

    wire ctrl_bit_take = sclk_rise & (ridx_ff < RIDX_CTRL_END);
    wire ctrl_done = sclk_rise & (ridx_ff == RIDX_CTRL_END - 4'h1);
    wire [CTRL_W-1:0] ctrl_full = {ctrl_shift_ff[CTRL_W-2:0], din_sync};
    // Only the low two channel bits matter; top bit and don't-care bits dropped
    wire [1:0] ctrl_chan = {ctrl_full[CHAN_MID_POS], ctrl_full[CHAN_LOW_POS]};
    wire slot_end = sclk_rise & (ridx_ff == RIDX_LAST);

    // Shift MSB first on the first eight rises of each slot
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_shift_ff <= CTRL_RESET;
        end
        else if (ctrl_bit_take)
        begin
            ctrl_shift_ff <= ctrl_full;
        end
    end

    // Whole word visible once its eighth bit is in
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_word_ff <= CTRL_RESET;
        end
        else if (ctrl_done)
        begin
            ctrl_word_ff <= ctrl_full;
        end
    end

    // The word picks the channel of the following slot, so it is held pending
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            chan_next_ff <= CHAN_DEFAULT;
        end
        else if (ctrl_done)
        begin
            chan_next_ff <= ctrl_chan;
        end
    end

    // Active channel moves on at the end of each full slot
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            chan_ff <= CHAN_DEFAULT;
        end
        else if (slot_end)
        begin
            chan_ff <= chan_next_ff;
        end
    end

    // ---------------------------------------------------------------------
    // Sample and result shifter
    // ---------------------------------------------------------------------
    logic [RES_W-1:0] code_sel;
    logic [RES_W-1:0] out_shift_ff;
    logic [RES_W-1:0] result_ff;
    logic result_valid_ff;

    // Input multiplexer of the track switch
    always_comb
    begin
        unique case (chan_ff)
            2'h0: code_sel = conv_codes.analog_input_1;
            2'h1: code_sel = conv_codes.analog_input_2;
            2'h2: code_sel = conv_codes.analog_input_3;
            2'h3: code_sel = conv_codes.analog_input_4;
        endcase
    end

    // Hold starts on the 4th falling edge: the code is frozen there
    wire hold_start = sclk_fall & (nxt_fidx == FIDX_MSB);
    wire shift_on = sclk_fall & (nxt_fidx > FIDX_MSB);

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            out_shift_ff <= '0;
        end
        else if (hold_start)
        begin
            out_shift_ff <= code_sel;
        end
        else if (shift_on)
        begin
            out_shift_ff <= {out_shift_ff[RES_W-2:0], 1'b0};
        end
    end

    // Captured result and a one-cycle strobe when it is taken
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            result_ff <= '0;
            result_valid_ff <= 1'b0;
        end
        else
        begin
            result_valid_ff <= hold_start;
            if (hold_start)
            begin
                result_ff <= code_sel;
            end
        end
    end

    // ---------------------------------------------------------------------
    // Serial output
    // ---------------------------------------------------------------------
    logic dout_ff;
    logic dout_oe_ff;

    // Zeros lead the MSB; data bits change on falling edges for host rise sampling
    wire nxt_dout = ~cs_low ? 1'b0 :
                    hold_start ? code_sel[RES_W-1] :
                    shift_on ? out_shift_ff[RES_W-2] :
                    (fall_event & (nxt_fidx < FIDX_MSB)) ? 1'b0 :
                    dout_ff;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            dout_ff <= 1'b0;
            dout_oe_ff <= 1'b0;
        end
        else
        begin
            dout_ff <= nxt_dout;
            dout_oe_ff <= cs_low;
        end
    end

    // ---------------------------------------------------------------------
    // Status registers
    // ---------------------------------------------------------------------
    logic powered_ff;
    logic tracking_ff;

    // Power state tracks chip select and the slot phase
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            powered_ff <= 1'b0;
            tracking_ff <= 1'b0;
        end
        else
        begin
            powered_ff <= nxt_powered;
            tracking_ff <= nxt_tracking;
        end
    end

    // ---------------------------------------------------------------------
    // Outputs, all straight from flops
    // ---------------------------------------------------------------------
    assign dout = dout_ff;
    assign dout_oe = dout_oe_ff;
    assign powered = powered_ff;
    assign tracking = tracking_ff;
    assign active_channel = chan_ff;
    assign channel_select_control = ctrl_word_ff;
    assign last_result = result_ff;
    assign result_valid = result_valid_ff;

endmodule : qasc_serial_ctrl

// File: verification/qasc_serial_ctrl_props.sv
// Port-level assertions of the converter serial control block
module qasc_serial_ctrl_props
    import qasc_pkg::*;
#(
    parameter int RES_W = RESULT_W,
    parameter int SLOT_LEN = SLOT_CLKS
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Serial pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    // Core codes
    input wire qasc_inputs_type conv_codes,
    // Status
    input wire logic powered,
    input wire logic tracking,
    input wire logic [1:0] active_channel,
    input wire logic [CTRL_W-1:0] channel_select_control,
    input wire logic [RES_W-1:0] last_result,
    input wire logic result_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Helpers
    // ----
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);
    // Code of the channel now converting
    wire logic [RES_W-1:0] sel_code = conv_codes[RES_W*active_channel +: RES_W];
    // Pin latency is up to three cycles, so eight settles every case
    sequence s_cs_idle;
        cs_n [*8];
    endsequence
    sequence s_cs_active;
        !cs_n [*8];
    endsequence

    // ----
    // Assertions
    // ----
    a_oe_idle_off: assert property (s_cs_idle |-> !dout_oe)
        else $error("dout enabled while deselected");
    a_oe_active_on: assert property (s_cs_active |-> dout_oe)
        else $error("dout released while selected");
    a_power_idle_off: assert property (s_cs_idle |-> !powered)
        else $error("powered while deselected");
    a_lead_zero: assert property (tracking |-> !dout)
        else $error("dout high during track");
    a_msb_first: assert property (result_valid |-> dout == last_result[RES_W-1] && !tracking && powered)
        else $error("result MSB not shown at capture");
    a_capture_code: assert property (result_valid |-> last_result == sel_code)
        else $error("captured code is not the active channel");
    a_valid_pulse: assert property (result_valid |=> !result_valid [*8])
        else $error("result valid longer than one cycle");
    a_channel_gap: assert property ($changed(active_channel) |-> !powered)
        else $error("channel changed inside a conversion");
    a_word_late: assert property ($changed(channel_select_control) |-> powered && !tracking)
        else $error("control word latched at a wrong point");
    a_gap_sleep: assert property ($fell(powered) && !cs_n && $past(cs_n, 8) == 1'b0 |-> !dout ##1 !powered [*3])
        else $error("no quiet gap between conversions");
endmodule : qasc_serial_ctrl_props

// File: verification/qasc_host_model.sv
// Host serial master model driving chip select, serial clock and data in
module qasc_host_model
    import qasc_pkg::*;
(
    // Clock
    input wire logic clock,
    // Serial pins
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Half period of 16 cycles gives 3.125 MHz, under the ceiling
    localparam int HALF = 16;

    // Idle pins: deselected, clock parked low
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // Open a frame, optionally with clock and select falling together
    task automatic open_frame(input logic together);
        @(posedge clock);
        if (together)
        begin
            sclk <= 1'b1;
            repeat (HALF) @(posedge clock);
            sclk <= 1'b0;
        end
        cs_n <= 1'b0;
        repeat (HALF) @(posedge clock);
    endtask : open_frame

    // One 16-clock slot; data changes after falls, dout sampled before rises
    task automatic run_slot(input logic [7:0] word, output logic [15:0] seen);
        for (int k = 0; k < SLOT_CLKS; k++)
        begin
            if (sclk)
                sclk <= 1'b0;
            din <= (k < CTRL_W) ? word[CTRL_W-1-k] : ~din;
            repeat (HALF - 1) @(posedge clock);
            seen[SLOT_CLKS-1-k] = dout_pin;
            @(posedge clock);
            sclk <= 1'b1;
            repeat (HALF) @(posedge clock);
        end
    endtask : run_slot

    // Close after whole slots, then park the clock low while deselected
    task automatic close_frame();
        cs_n <= 1'b1;
        repeat (HALF) @(posedge clock);
        sclk <= 1'b0;
        repeat (HALF) @(posedge clock);
    endtask : close_frame
endmodule : qasc_host_model

// File: verification/qasc_serial_ctrl_tb.sv
// Self-checking bench of the converter serial control block
module qasc_serial_ctrl_tb
    import qasc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Signals and instances
    // ----
    localparam logic [7:0] WORDS [5] = '{8'hd5, 8'h7a, 8'he0, 8'h2f, 8'h00};
    logic clock = 1'b0;
    logic srst = 1'b1;
    wire logic cs_n;
    wire logic sclk;
    wire logic din;
    logic dout;
    logic dout_oe;
    logic powered;
    logic tracking;
    logic [1:0] active_channel;
    logic [CTRL_W-1:0] channel_select_control;
    logic [RESULT_W-1:0] last_result;
    logic result_valid;
    qasc_inputs_type conv_codes = '{12'h000, 12'hfff, 12'h001, 12'ha5c};
    // No pull on the pin, so a released dout reads as high impedance (z)
    wire dout_pin = dout_oe ? dout : 1'bz;
    int miscompares = 0;
    int tests_run = 0;
    int valid_pulses = 0;

    always #5 clock = ~clock;

    // Counts capture strobes; exactly one is expected per slot
    always @(posedge clock)
    begin
        if (result_valid === 1'b1)
            valid_pulses <= valid_pulses + 1;
    end

    qasc_serial_ctrl dut (.clock, .srst, .cs_n, .sclk, .din, .dout, .dout_oe, .conv_codes, .powered,
        .tracking, .active_channel, .channel_select_control, .last_result, .result_valid);
    qasc_host_model host (.clock, .cs_n, .sclk, .din, .dout_pin);

    // ----
    // Helpers
    // ----
    function automatic logic [11:0] code_of(input logic [1:0] ch);
        return conv_codes[12*ch +: 12];
    endfunction : code_of

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Three zero clocks, twelve result bits, then a zero in the gap
    task automatic slot_chk(input logic [7:0] word, input logic [1:0] ch);
        logic [15:0] seen;
        int pulses;
        pulses = valid_pulses;
        host.run_slot(word, seen);
        chk("slot bits", {3'h0, code_of(ch), 1'b0}, seen);
        chk("last result", 16'(code_of(ch)), 16'(last_result));
        chk("capture strobes", 16'h1, 16'(valid_pulses - pulses));
    endtask : slot_chk

    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // ----
    // Scenarios
    // ----
    task automatic test_first();
        chk("oe idle", 16'h0, 16'(dout_oe));
        chk("channel reset", 16'h0, 16'(active_channel));
        host.open_frame(1'b0);
        chk("powered", 16'h1, 16'(powered));
        chk("oe on", 16'h1, 16'(dout_oe));
        chk("tracking", 16'h1, 16'(tracking));
        slot_chk(8'h08, 2'h0);
        chk("control word", 16'h08, 16'(channel_select_control));
        chk("next channel", 16'h1, 16'(active_channel));
        host.close_frame();
        chk("oe off", 16'h0, 16'(dout_oe));
        chk("powered off", 16'h0, 16'(powered));
        $display("test_first done");
    endtask : test_first

    // Back to back slots, junk in ignored bits and in the top channel bit
    task automatic test_back_to_back();
        logic [1:0] prev;
        prev = 2'h1;
        host.open_frame(1'b0);
        for (int i = 0; i < 5; i++)
        begin
            slot_chk(WORDS[i], prev);
            prev = WORDS[i][4:3];
            chk("channel", 16'(prev), 16'(active_channel));
            chk("gap power", 16'h0, 16'(powered));
        end
        host.close_frame();
        $display("test_back_to_back done");
    endtask : test_back_to_back

    task automatic test_together();
        host.open_frame(1'b1);
        slot_chk(8'h10, 2'h0);
        chk("aligned word", 16'h10, 16'(channel_select_control));
        slot_chk(8'h00, 2'h2);
        host.close_frame();
        $display("test_together done");
    endtask : test_together

    // ----
    // Sequence and watchdog
    // ----
    initial
    begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        test_first();
        test_back_to_back();
        test_together();
        complete_run();
    end

    // Cuts a hang short
    initial
    begin
        repeat (60000) @(posedge clock);
        miscompares++;
        complete_run();
    end
endmodule : qasc_serial_ctrl_tb

bind qasc_serial_ctrl qasc_serial_ctrl_props #(.RES_W(RES_W), .SLOT_LEN(SLOT_LEN)) u_props (.clock, .srst,
    .cs_n, .sclk, .din, .dout, .dout_oe, .conv_codes, .powered, .tracking, .active_channel,
    .channel_select_control, .last_result, .result_valid);
